// ==== rtl/flash_ctrl_defs.svh ====
// Offsets, field positions, reset values, command codes and timing counts of the flash controller.
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH

`define REG_CTRL          8'h00
`define REG_CONFIG        8'h04
`define REG_ADDR          8'h08
`define REG_DATA          8'h0C
`define REG_STATUS        8'h10
`define REG_RDATA         8'h14
`define REG_PAGE          8'h18
`define REG_PAGE_COUNT    8'h1C

`define CTRL_OP_LSB       0
`define CTRL_OP_MSB       3
`define CTRL_WAIT_BIT     8
`define CFG_RESET_BIT     0
`define CFG_PROG_EN_BIT   1
`define CFG_WORD_BIT      2
`define CONFIG_RESET      3'h0

`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_PIN_BIT        2
`define ST_REFUSED_BIT    3

`define CMD_READ_ARRAY    8'hFF
`define CMD_READ_ID       8'h90
`define CMD_READ_QUERY    8'h98
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_ERASE_SETUP   8'h20
`define CMD_CONFIRM       8'hD0
`define CMD_PROGRAM_SETUP 8'h40
`define CMD_PAGE_SETUP    8'hE8
`define CMD_SUSPEND       8'hB0
`define CMD_BUSY_CONFIG   8'hB8
`define CMD_LOCK_SETUP    8'h60
`define CMD_LOCK_SET      8'h01
`define CMD_ONETIME_SETUP 8'hC0

`define PAGE_DEPTH        32
`define PAGE_PTR_W        5

`define CLK_PERIOD_NS     20
`define T_SETUP_NS        40
`define T_WE_LOW_NS       70
`define T_HOLD_NS         20
`define T_READ_ACC_NS     120
`define T_RECOVER_NS      40
`define T_BUSY_SETTLE_NS  200
`define NS_TO_CYC(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SETUP         4'(`NS_TO_CYC(`T_SETUP_NS))
`define CYC_WE_LOW        4'(`NS_TO_CYC(`T_WE_LOW_NS))
`define CYC_HOLD          4'(`NS_TO_CYC(`T_HOLD_NS))
`define CYC_READ_ACC      4'(`NS_TO_CYC(`T_READ_ACC_NS))
`define CYC_RECOVER       4'(`NS_TO_CYC(`T_RECOVER_NS))
`define CYC_BUSY_SETTLE   4'(`NS_TO_CYC(`T_BUSY_SETTLE_NS))

`endif

// ==== rtl/flash_ctrl_pkg.sv ====
// Types shared by the flash controller modules.
package flash_ctrl_pkg;

  typedef enum logic [3:0] {
    OP_READ_ARRAY,
    OP_READ_ID,
    OP_READ_QUERY,
    OP_READ_STATUS,
    OP_CLEAR_STATUS,
    OP_ERASE,
    OP_PROGRAM,
    OP_PAGE_PROGRAM,
    OP_SUSPEND,
    OP_RESUME,
    OP_BUSY_CONFIG,
    OP_LOCK_SET,
    OP_LOCK_CLEAR,
    OP_ONETIME_PROGRAM,
    OP_PLAIN_READ
  } op_e;

  typedef enum logic [1:0] {
    CYC_WRITE,
    CYC_READ,
    CYC_END
  } cyc_kind_e;

endpackage : flash_ctrl_pkg

// ==== rtl/flash_cycle_if.sv ====
// Request and answer of one flash bus cycle between sequencer and pin engine.
`timescale 1ns/100ps
interface flash_cycle_if;
  logic        req;
  logic        write;
  logic [22:0] addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;

  modport requester (output req, output write, output addr, output wdata, input ack, input rdata);
  modport engine    (input req, input write, input addr, input wdata, output ack, output rdata);
endinterface : flash_cycle_if

// ==== rtl/flash_page_store.sv ====
// Word store that holds the data of one page-buffer program.
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module flash_page_store
  import flash_ctrl_pkg::*;
(
  input  wire logic                   core_clk_in,
  input  wire logic                   wr_in,
  input  wire logic [`PAGE_PTR_W-1:0] wr_ptr_in,
  input  wire logic [15:0]            wr_data_in,
  input  wire logic [`PAGE_PTR_W-1:0] rd_ptr_in,
  output logic      [15:0]            rd_data_out
);
  logic [15:0] words [`PAGE_DEPTH];

  always_ff @(posedge core_clk_in) begin
    if (wr_in) begin
      words[wr_ptr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = words[rd_ptr_in];
endmodule : flash_page_store

// ==== rtl/flash_bus_engine.sv ====
// Pin engine that performs one write or read cycle on the flash bus.
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module flash_bus_engine
  import flash_ctrl_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  flash_cycle_if.engine    cyc,
  input  wire logic [15:0] flash_dq_in,
  output logic      [22:0] flash_addr_out,
  output logic      [15:0] flash_dq_out,
  output logic             flash_dq_oe_out,
  output logic             chip_select_a_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out
);
  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_RECOVER} eng_state_e;

  eng_state_e  state;
  logic [3:0]  count;
  logic        is_write;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state               <= E_IDLE;
      count               <= 4'h0;
      is_write            <= 1'b0;
      flash_addr_out      <= 23'h000000;
      flash_dq_out        <= 16'h0000;
      flash_dq_oe_out     <= 1'b0;
      chip_select_a_n_out <= 1'b1;
      flash_oe_n_out      <= 1'b1;
      flash_we_n_out      <= 1'b1;
      cyc.ack             <= 1'b0;
      cyc.rdata           <= 16'h0000;
    end else begin
      cyc.ack <= 1'b0;
      unique case (state)
        E_IDLE: begin
          if (cyc.req) begin
            is_write            <= cyc.write;
            flash_addr_out      <= cyc.addr;
            flash_dq_out        <= cyc.wdata;
            flash_dq_oe_out     <= cyc.write;
            chip_select_a_n_out <= 1'b0;
            count               <= `CYC_SETUP;
            state               <= E_SETUP;
          end
        end
        E_SETUP: begin
          if (count == 4'h1) begin
            // Only one of the two strobes is ever pulled low in a cycle.
            flash_we_n_out <= ~is_write;
            flash_oe_n_out <= is_write;
            count          <= is_write ? `CYC_WE_LOW : `CYC_READ_ACC;
            state          <= E_STROBE;
          end else begin
            count <= count - 4'h1;
          end
        end
        E_STROBE: begin
          if (count == 4'h1) begin
            flash_we_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            if (!is_write) begin
              cyc.rdata <= flash_dq_in;
            end
            count <= `CYC_HOLD;
            state <= E_HOLD;
          end else begin
            count <= count - 4'h1;
          end
        end
        E_HOLD: begin
          // Address and data stay put until after the write enable edge that latches them.
          if (count == 4'h1) begin
            chip_select_a_n_out <= 1'b1;
            flash_dq_oe_out     <= 1'b0;
            count               <= `CYC_RECOVER;
            state               <= E_RECOVER;
          end else begin
            count <= count - 4'h1;
          end
        end
        E_RECOVER: begin
          if (count == 4'h1) begin
            cyc.ack <= 1'b1;
            state   <= E_IDLE;
          end else begin
            count <= count - 4'h1;
          end
        end
      endcase
    end
  end
endmodule : flash_bus_engine

// ==== rtl/flash_host_ctrl.sv ====
// Host controller that drives a parallel NOR flash through its command cycles.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module flash_host_ctrl
  import flash_ctrl_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic      [22:0] flash_addr_out,
  output logic      [15:0] flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [15:0] flash_dq_in,
  output logic             chip_select_a_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out,
  output logic             reset_powerdown_n_out,
  output logic             byte_mode_n_out,
  output logic             program_enable_supply_out,
  input  wire logic        busy_indicator_pin_in
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT_CYCLE, S_SETTLE, S_WAIT_READY} seq_state_e;

  flash_cycle_if cyc ();

  seq_state_e            state;
  op_e                   op;
  logic                  wait_ready;
  logic [5:0]            step;
  logic [3:0]            settle;
  logic [22:0]           target_addr;
  logic [15:0]           target_data;
  logic [15:0]           read_data;
  logic [`PAGE_PTR_W:0]  page_count;
  logic                  done;
  logic                  refused;
  logic [2:0]            config_bits;
  logic                  req;
  logic                  req_write;
  logic [22:0]           req_addr;
  logic [15:0]           req_data;
  logic [15:0]           page_word;
  cyc_kind_e             kind;
  logic [22:0]           cyc_addr;
  logic [7:0]            cyc_code;
  logic                  cyc_is_data;
  logic                  start;
  logic                  alters;
  logic                  start_ok;
  logic [5:0]            page_last;

  assign cyc.req   = req;
  assign cyc.write = req_write;
  assign cyc.addr  = req_addr;
  assign cyc.wdata = req_data;

  flash_bus_engine u_engine (
    .core_clk_in         (core_clk_in),
    .rst_in              (rst_in),
    .cyc                 (cyc),
    .flash_dq_in         (flash_dq_in),
    .flash_addr_out      (flash_addr_out),
    .flash_dq_out        (flash_dq_out),
    .flash_dq_oe_out     (flash_dq_oe_out),
    .chip_select_a_n_out (chip_select_a_n_out),
    .flash_oe_n_out      (flash_oe_n_out),
    .flash_we_n_out      (flash_we_n_out)
  );

  flash_page_store u_page (
    .core_clk_in (core_clk_in),
    .wr_in       (reg_wr_in && reg_addr_in == `REG_PAGE && state == S_IDLE && page_count < 6'(`PAGE_DEPTH)),
    .wr_ptr_in   (page_count[`PAGE_PTR_W-1:0]),
    .wr_data_in  (reg_wdata_in[15:0]),
    .rd_ptr_in   (5'(step - 6'h2)),
    .rd_data_out (page_word)
  );

  assign start     = reg_wr_in && reg_addr_in == `REG_CTRL && state == S_IDLE;
  assign page_last = 6'(page_count + 6'h2);

  // Orders that alter memory are refused while the program supply is switched off.
  always_comb begin
    unique case (op_e'(reg_wdata_in[`CTRL_OP_MSB:`CTRL_OP_LSB]))
      OP_ERASE, OP_PROGRAM, OP_PAGE_PROGRAM, OP_LOCK_SET, OP_LOCK_CLEAR, OP_ONETIME_PROGRAM: alters = 1'b1;
      default: alters = 1'b0;
    endcase
  end

  always_comb begin
    start_ok = reg_wdata_in[`CTRL_OP_MSB:`CTRL_OP_LSB] <= 4'(OP_PLAIN_READ);
    if (alters && (!config_bits[`CFG_PROG_EN_BIT] || !config_bits[`CFG_RESET_BIT])) begin
      start_ok = 1'b0;
    end
    if (op_e'(reg_wdata_in[`CTRL_OP_MSB:`CTRL_OP_LSB]) == OP_PAGE_PROGRAM && page_count == 6'h0) begin
      start_ok = 1'b0;
    end
  end

  // Each order is spelled out as its list of bus cycles, one per step.
  always_comb begin
    kind        = CYC_END;
    cyc_addr    = target_addr;
    cyc_code    = `CMD_READ_ARRAY;
    cyc_is_data = 1'b0;
    unique case (op)
      OP_READ_ARRAY: begin
        if (step == 6'h0) begin
          kind = CYC_WRITE;
        end
      end
      OP_READ_ID, OP_READ_QUERY, OP_READ_STATUS: begin
        cyc_code = (op == OP_READ_ID) ? `CMD_READ_ID :
                   (op == OP_READ_QUERY) ? `CMD_READ_QUERY : `CMD_READ_STATUS;
        if (step == 6'h0) begin
          kind = CYC_WRITE;
        end
        if (step == 6'h1) begin
          kind = CYC_READ;
        end
      end
      OP_CLEAR_STATUS: begin
        cyc_code = `CMD_CLEAR_STATUS;
        if (step == 6'h0) begin
          kind = CYC_WRITE;
        end
      end
      OP_ERASE: begin
        cyc_code = (step == 6'h0) ? `CMD_ERASE_SETUP : `CMD_CONFIRM;
        if (step < 6'h2) begin
          kind = CYC_WRITE;
        end
      end
      OP_PROGRAM, OP_ONETIME_PROGRAM, OP_BUSY_CONFIG: begin
        cyc_code    = (op == OP_PROGRAM) ? `CMD_PROGRAM_SETUP :
                      (op == OP_ONETIME_PROGRAM) ? `CMD_ONETIME_SETUP : `CMD_BUSY_CONFIG;
        cyc_is_data = step == 6'h1;
        if (step < 6'h2) begin
          kind = CYC_WRITE;
        end
      end
      OP_PAGE_PROGRAM: begin
        // Setup, count, one write per stored word, then the confirm.
        if (step <= page_last) begin
          kind = CYC_WRITE;
        end
        if (step == 6'h0) begin
          cyc_code = `CMD_PAGE_SETUP;
        end else if (step == 6'h1) begin
          cyc_code = 8'(page_count - 6'h1);
        end else if (step == page_last) begin
          cyc_code = `CMD_CONFIRM;
        end else begin
          cyc_is_data = 1'b1;
          cyc_addr    = 23'(target_addr + 23'(step - 6'h2));
        end
      end
      OP_SUSPEND: begin
        cyc_code = `CMD_SUSPEND;
        if (step == 6'h0) begin
          kind = CYC_WRITE;
        end
      end
      OP_RESUME: begin
        // The device picks which suspended operation resumes, the program one first.
        cyc_code = `CMD_CONFIRM;
        if (step == 6'h0) begin
          kind = CYC_WRITE;
        end
      end
      OP_LOCK_SET, OP_LOCK_CLEAR: begin
        cyc_code = (step == 6'h0) ? `CMD_LOCK_SETUP :
                   (op == OP_LOCK_SET) ? `CMD_LOCK_SET : `CMD_CONFIRM;
        if (step < 6'h2) begin
          kind = CYC_WRITE;
        end
      end
      OP_PLAIN_READ: begin
        if (step == 6'h0) begin
          kind = CYC_READ;
        end
      end
      default: begin
        kind = CYC_END;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state     <= S_IDLE;
      op        <= OP_READ_ARRAY;
      step      <= 6'h0;
      settle    <= 4'h0;
      req       <= 1'b0;
      req_write <= 1'b0;
      req_addr  <= 23'h000000;
      req_data  <= 16'h0000;
      read_data <= 16'h0000;
    end else begin
      req <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (start && start_ok) begin
            op    <= op_e'(reg_wdata_in[`CTRL_OP_MSB:`CTRL_OP_LSB]);
            step  <= 6'h0;
            state <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (kind == CYC_END) begin
            settle <= `CYC_BUSY_SETTLE;
            state  <= (wait_ready && op != OP_PLAIN_READ) ? S_SETTLE : S_IDLE;
          end else begin
            req       <= 1'b1;
            req_write <= kind == CYC_WRITE;
            req_addr  <= cyc_addr;
            // Command codes go out on the low byte with the upper byte held at zero.
            req_data  <= cyc_is_data ? (op == OP_PAGE_PROGRAM ? page_word : target_data) : {8'h00, cyc_code};
            state     <= S_WAIT_CYCLE;
          end
        end
        S_WAIT_CYCLE: begin
          if (cyc.ack) begin
            if (!req_write) begin
              read_data <= cyc.rdata;
            end
            step  <= 6'(step + 6'h1);
            state <= S_ISSUE;
          end
        end
        S_SETTLE: begin
          settle <= settle - 4'h1;
          if (settle == 4'h1) begin
            state <= S_WAIT_READY;
          end
        end
        S_WAIT_READY: begin
          // A released busy pin reads high through the board pull-up.
          if (busy_indicator_pin_in) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wait_ready  <= 1'b0;
      target_addr <= 23'h000000;
      target_data <= 16'h0000;
      config_bits <= `CONFIG_RESET;
    end else if (reg_wr_in) begin
      if (start) wait_ready <= reg_wdata_in[`CTRL_WAIT_BIT];
      if (reg_addr_in == `REG_ADDR) target_addr <= reg_wdata_in[22:0];
      if (reg_addr_in == `REG_DATA) target_data <= reg_wdata_in[15:0];
      if (reg_addr_in == `REG_CONFIG) config_bits <= reg_wdata_in[2:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      page_count <= 6'h0;
    end else if (state == S_ISSUE && kind == CYC_END && op == OP_PAGE_PROGRAM) begin
      page_count <= 6'h0;
    end else if (reg_wr_in && reg_addr_in == `REG_PAGE && state == S_IDLE && page_count < 6'(`PAGE_DEPTH)) begin
      page_count <= 6'(page_count + 6'h1);
    end else if (reg_wr_in && reg_addr_in == `REG_PAGE_COUNT && state == S_IDLE) begin
      page_count <= 6'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      done    <= 1'b0;
      refused <= 1'b0;
    end else if (start) begin
      done    <= 1'b0;
      refused <= !start_ok;
    end else if ((state == S_ISSUE && kind == CYC_END && !(wait_ready && op != OP_PLAIN_READ))
                 || (state == S_WAIT_READY && busy_indicator_pin_in)) begin
      done <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `REG_CTRL:       reg_rdata_out <= {23'h000000, wait_ready, 4'h0, op};
        `REG_CONFIG:     reg_rdata_out <= {29'h00000000, config_bits};
        `REG_ADDR:       reg_rdata_out <= {9'h000, target_addr};
        `REG_DATA:       reg_rdata_out <= {16'h0000, target_data};
        `REG_STATUS:     reg_rdata_out <= {28'h0000000, refused, busy_indicator_pin_in, done, state != S_IDLE};
        `REG_RDATA:      reg_rdata_out <= {16'h0000, read_data};
        `REG_PAGE_COUNT: reg_rdata_out <= {26'h0000000, page_count};
        default:         reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reset_powerdown_n_out     <= 1'b0;
      byte_mode_n_out           <= 1'b0;
      program_enable_supply_out <= 1'b0;
    end else begin
      reset_powerdown_n_out     <= config_bits[`CFG_RESET_BIT];
      byte_mode_n_out           <= config_bits[`CFG_WORD_BIT];
      program_enable_supply_out <= config_bits[`CFG_PROG_EN_BIT];
    end
  end
endmodule : flash_host_ctrl

// ==== tb/flash_dev_model.sv ====
// Behavioural flash device that answers the controller's bus cycles.
`timescale 1ns/100ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5A,  // Arbitrary value.
  parameter logic [7:0] PART_CODE  = 8'hA7   // Arbitrary value.
) (
  input  wire logic        core_clk_in,
  input  wire logic [22:0] addr_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        cs_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        rp_n_in,
  input  wire logic        program_enable_supply_in,
  output logic      [15:0] dq_out,
  output logic             busy_out
);
  logic [15:0] mem [logic [22:0]];
  logic [127:0] locks = '0;
  logic [7:0]  st = 8'h00;
  logic [7:0]  mode = 8'hFF;
  logic [7:0]  err = 8'h00;
  logic [7:0]  c;
  logic [7:0]  n;
  logic [15:0] rd = 16'h0;
  logic [15:0] last = 16'h0;
  logic [15:0] cnt = 16'h0;
  logic        susp = 1'b0;
  int          busy = 0;
  logic [38:0] log [$];
  wire         ok = program_enable_supply_in && !locks[addr_in[22:16]];
  assign busy_out = !rp_n_in || busy == 0 || susp;
  assign dq_out = (!cs_n_in && !oe_n_in && rp_n_in) ? rd : ~last;
  always @(posedge core_clk_in) begin
    if (busy > 0 && !susp) busy--;
    last <= dq_out;
    case (mode)
      8'h90: rd <= addr_in[0] ? {8'h00, PART_CODE} : {8'h00, MAKER_CODE};
      8'h98: rd <= 16'h0033;
      8'h70: rd <= {8'h00, (busy == 0 ? 8'h80 : 8'h00) | err};
      default: rd <= mem.exists(addr_in) ? mem[addr_in] : 16'hFFFF;
    endcase
  end
  always @(posedge we_n_in) if (!cs_n_in && rp_n_in) begin
    c = dq_in[7:0];
    log.push_back({addr_in, dq_in});
    n = st;
    st = 8'h00;
    if (n == 8'h20) begin
      if (c == 8'hD0 && ok) foreach (mem[k]) if (k[22:16] == addr_in[22:16]) mem[k] = 16'hFFFF;
      if (c == 8'hD0 && ok) busy = 20; else err = 8'h30;
    end else if (n == 8'h40 || n == 8'h10 || n == 8'hC0) begin
      if (ok) mem[addr_in] = dq_in;
      if (ok) busy = 20; else err = 8'h10;
    end else if (n == 8'h60 && program_enable_supply_in) begin
      if (c == 8'h01) locks[addr_in[22:16]] = 1'b1; else locks = '0;
    end else if (n == 8'hE8) begin
      cnt = dq_in + 16'h1;
      st = 8'hE9;
    end else if (n == 8'hE9 && cnt != 0) begin
      cnt--;
      st = 8'hE9;
    end else if (n == 8'hE9) begin
      if (ok) busy = 20; else err = 8'h10;
    end else if (n != 8'hB8) begin
      if (c == 8'hB0) susp = busy != 0;
      if (c == 8'hD0) susp = 1'b0;
      if (c == 8'h50) err = 8'h00;
      if (c inside {8'hFF, 8'h90, 8'h98, 8'h70}) mode = c;
      if (c inside {8'h20, 8'h40, 8'h10, 8'hE8, 8'h60, 8'hB8, 8'hC0}) st = c;
      if (c inside {8'h20, 8'h40, 8'h10, 8'hE8, 8'hC0}) mode = 8'h70;
    end
  end
endmodule : flash_dev_model

// ==== tb/flash_host_ctrl_sva.sv ====
// Checker of the controller's flash bus and register read port.
`timescale 1ns/100ps
module flash_host_ctrl_sva (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_rdata_out,
  input  wire logic [22:0] flash_addr_out,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe_out,
  input  wire logic        chip_select_a_n_out,
  input  wire logic        flash_oe_n_out,
  input  wire logic        flash_we_n_out,
  input  wire logic        program_enable_supply_out,
  input  wire logic        busy_indicator_pin_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  property p_oe_we; !(!flash_oe_n_out && !flash_we_n_out); endproperty
  a_oe_we: assert property (p_oe_we) else $error("oe and we low together");
  property p_we_cs; !flash_we_n_out |-> !chip_select_a_n_out && flash_dq_oe_out; endproperty
  a_we_cs: assert property (p_we_cs) else $error("write strobe without select");
  property p_we_len; $fell(flash_we_n_out) |-> (!flash_we_n_out) [*4] ##1 flash_we_n_out; endproperty
  a_we_len: assert property (p_we_len) else $error("write strobe length");
  property p_latch; $rose(flash_we_n_out) |-> $stable(flash_addr_out) && $stable(flash_dq_out)
    && !chip_select_a_n_out; endproperty
  a_latch: assert property (p_latch) else $error("address or data moved at latch");
  property p_oe_dq; !flash_oe_n_out |-> !flash_dq_oe_out && !chip_select_a_n_out; endproperty
  a_oe_dq: assert property (p_oe_dq) else $error("driving data while reading");
  property p_code; $fell(flash_we_n_out) && !program_enable_supply_out
    |-> !(flash_dq_out[7:0] inside {8'h20, 8'h40, 8'hE8, 8'h60, 8'hC0}); endproperty
  a_code: assert property (p_code) else $error("altering command with supply off");
  property p_rdata; !$past(reg_rd_in) |-> reg_rdata_out == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  property p_cs_end; $rose(chip_select_a_n_out) |-> flash_we_n_out && flash_oe_n_out && !flash_dq_oe_out;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("deselect before strobes end");
  c_write: cover property ($fell(flash_we_n_out));
  c_read: cover property ($fell(flash_oe_n_out));
  c_busy: cover property ($fell(busy_indicator_pin_in));
endmodule : flash_host_ctrl_sva
bind flash_host_ctrl flash_host_ctrl_sva i_sva (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench of the flash host controller.
`timescale 1ns/100ps
`include "flash_ctrl_defs.svh"
module tb_top
  import flash_ctrl_pkg::*;
;
  localparam logic [7:0]  MAKER = 8'h5A;  // Arbitrary value.
  localparam logic [22:0] A = 23'h050004;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  ra = 8'h00;
  logic [31:0] rw = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdat;
  logic [31:0] d;
  logic [22:0] fa;
  logic [15:0] fq;
  logic [15:0] fd;
  logic        oe, cs, oen, wen, rpn, pe, bz, bm;
  logic        seen_bz = 1'b0;
  int          fails = 0;
  int          comparisons = 0;
  int          cyc = 0;
  flash_host_ctrl i_dut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(ra), .reg_wdata_in(rw), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_rdata_out(rdat), .flash_addr_out(fa), .flash_dq_out(fq), .flash_dq_oe_out(oe),
    .flash_dq_in(fd), .chip_select_a_n_out(cs), .flash_oe_n_out(oen), .flash_we_n_out(wen),
    .reset_powerdown_n_out(rpn), .byte_mode_n_out(bm), .program_enable_supply_out(pe), .busy_indicator_pin_in(bz));
  flash_dev_model #(.MAKER_CODE(MAKER)) i_dev (.core_clk_in(clk), .addr_in(fa), .dq_in(fq), .cs_n_in(cs),
    .oe_n_in(oen), .we_n_in(wen), .rp_n_in(rpn), .program_enable_supply_in(pe), .dq_out(fd), .busy_out(bz));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (!bz) seen_bz <= 1'b1;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    ra <= a;
    rw <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdat;
  endtask : rd
  task automatic run(input logic [3:0] op, input logic [22:0] a, input logic [15:0] v);
    int n;
    wr(`REG_ADDR, {9'h0, a});
    wr(`REG_DATA, {16'h0, v});
    wr(`REG_CTRL, {23'h0, 1'b1, 4'h0, op});
    n = 0;
    d = 32'h1;
    while (d[`ST_BUSY_BIT] !== 1'b0 && n < 300) begin
      rd(`REG_STATUS);
      n++;
    end
    if (n == 300) begin
      fails++;
      $display("wrong value at %0t: controller stayed busy", $time);
    end
  endtask : run
  task automatic readback(input logic [3:0] op, input logic [22:0] a);
    run(op, a, 16'h0);
    rd(`REG_RDATA);
  endtask : readback
  task automatic t_refuse();
    wr(`REG_CONFIG, 32'h1);
    run(4'd5, A, 16'h0);
    chk(32'(d[`ST_REFUSED_BIT]), 32'h1);
    run(4'd15, A, 16'h0);
    chk(32'(d[`ST_REFUSED_BIT]), 32'h1);
    chk(32'(i_dev.log.size()), 32'h0);
    run(4'd0, A, 16'h0);
    chk(32'(i_dev.log[0][7:0]), 32'hFF);
    rd(8'h40);
    chk(d, 32'h0);
  endtask : t_refuse
  task automatic t_codes();
    logic [7:0] code [14] = '{8'hFF, 8'h90, 8'h98, 8'h70, 8'h50, 8'h20, 8'h40, 8'hE8, 8'hB0, 8'hD0, 8'hB8, 8'h60,
      8'h60, 8'hC0};
    for (int i = 0; i < 14; i++) begin
      if (i == 7) wr(`REG_PAGE, 32'h1);
      i_dev.log.delete();
      run(4'(i), 23'h020000, 16'h0003);
      chk(32'(i_dev.log[0][7:0]), 32'(code[i]));
    end
  endtask : t_codes
  task automatic t_page();
    for (int i = 0; i < 3; i++) wr(`REG_PAGE, 32'(i));
    i_dev.log.delete();
    run(4'd7, 23'h030000, 16'h0);
    chk(32'(i_dev.log.size()), 32'd6);
    chk(32'(i_dev.log[1][15:0]), 32'h2);
    chk(32'(i_dev.log[3][38:16]), 32'h030001);
    chk(32'(bm), 32'h1);
  endtask : t_page
  task automatic t_alter();
    seen_bz <= 1'b0;
    run(4'd5, A, 16'h0);
    chk(32'(seen_bz), 32'h1);
    chk(32'(bz), 32'h1);
    chk(32'(d[`ST_DONE_BIT]), 32'h1);
    chk(32'(d[`ST_PIN_BIT]), 32'h1);
    run(4'd11, A, 16'h0);
    run(4'd6, A, 16'hA55A);
    run(4'd0, A, 16'h0);
    readback(4'd14, A);
    chk(d, 32'hFFFF);
    run(4'd12, 23'h0, 16'h0);
    run(4'd6, A, 16'hA55A);
    run(4'd0, A, 16'h0);
    readback(4'd14, A);
    chk(d, 32'hA55A);
    run(4'd4, A, 16'h0);
    readback(4'd3, A);
    chk(d, 32'h80);
    readback(4'd1, 23'h0);
    chk(d, {24'h0, MAKER});
  endtask : t_alter
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_refuse();
    wr(`REG_CONFIG, 32'h7);
    t_codes();
    t_page();
    t_alter();
    end_of_test();
  end
endmodule : tb_top
